// file: logic/mqf_pkg.sv
// Package for the three-queue cell FIFO: layouts, reset values, widths.
// Assumes a single 20 MHz clock carries both the write and the read side.
package mqf_pkg;

  localparam int MQF_MEM_WORDS = 4096;
  localparam int MQF_BLOCK_SHIFT = 8;
  localparam int MQF_CFG_COUNT = 10;
  localparam int MQF_OUT_FIFO_DEPTH = 16;
  localparam int MQF_OUT_FIFO_WIDTH = 19;
  localparam int MQF_RESET_HOLD_EDGES = 4;
  localparam int MQF_GRANT_DELAY_EDGES = 2;

  // Bus-format field positions.
  localparam int MQF_FMT_INPUT_WIDTH = 0;
  localparam int MQF_FMT_INPUT_ORDER = 1;
  localparam int MQF_FMT_INPUT_STUFF = 2;
  localparam int MQF_FMT_OUTPUT_WIDTH = 3;
  localparam int MQF_FMT_OUTPUT_DESTUFF = 4;

  // Values after reset, then the stuff byte.
  localparam logic [4:0] MQF_RST_BUS_FORMAT = 5'h00;
  localparam logic [4:0] MQF_RST_Q1_LENGTH = 5'h08;
  localparam logic [3:0] MQF_RST_Q2_LENGTH = 4'h6;
  localparam logic [5:0] MQF_RST_CELL_SIZE = 6'h1b;
  localparam logic [8:0] MQF_RST_Q1_UPPER = 9'h047;
  localparam logic [8:0] MQF_RST_Q1_LOWER = 9'h046;
  localparam logic [8:0] MQF_RST_Q2_UPPER = 9'h033;
  localparam logic [8:0] MQF_RST_Q2_LOWER = 9'h032;
  localparam logic [8:0] MQF_RST_Q3_UPPER = 9'h00d;
  localparam logic [8:0] MQF_RST_Q3_LOWER = 9'h00c;
  localparam logic [8:0] MQF_STUFF_BYTE = 9'h000;

  typedef struct packed {
    logic [4:0] bus_format_cfg;
    logic [4:0] queue1_length;
    logic [3:0] queue2_length;
    logic [5:0] cell_size_words;
    logic [2:0][8:0] upper_threshold;
    logic [2:0][8:0] lower_threshold;
  } mqf_cfg_s;

  typedef struct packed {
    logic [12:0] wr_off;
    logic [12:0] wr_start;
    logic [12:0] rd_off;
    logic [12:0] used_words;
    logic [8:0] cells;
    logic full_n;
    logic threshold_flag;
    logic cell_ready;
  } mqf_queue_s;

  typedef struct packed {
    logic sof;
    logic [17:0] data;
  } mqf_word_s;

endpackage : mqf_pkg

// file: logic/mqf_cell_fifo.sv
// Three-queue cell FIFO with write-once configuration and a 16-word output buffer.
// Assumes write and read parties share sys_clk and drive inputs synchronously.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Output buffer: valid/ready on both sides.
module mqf_out_fifo
  import mqf_pkg::*;
#(
  parameter int WIDTH = MQF_OUT_FIFO_WIDTH,
  parameter int DEPTH = MQF_OUT_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } mqf_fifo_state_s;

  mqf_fifo_state_s st;
  mqf_fifo_state_s next_st;
  logic [WIDTH-1:0] store [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (st.count != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (st.count != '0);
  assign out_data = store[st.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
    if (push) begin
      store[st.wr_ptr] <= in_data;
    end
  end
endmodule : mqf_out_fifo

////////////////////////////////////////////////////////////////////////////////
// Top: configuration port, cell writer, three queues, cell reader.
module mqf_cell_fifo
  import mqf_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Write side.
  input wire logic [17:0] data_in,
  input wire logic [2:0] write_enable,
  input wire logic cell_start_in,
  input wire logic framing_abort_in,
  output logic data_path_grant,
  output logic framing_alarm_n,
  output logic [2:0] queue_full_n,
  output logic [2:0] queue_threshold_flag,
  // Read side.
  input wire logic read_enable,
  input wire logic [1:0] read_queue_sel,
  output logic [2:0] queue_cell_ready,
  output logic [17:0] data_out,
  output logic read_valid,
  input wire logic read_ready,
  output logic cell_start_out,
  // Configuration port.
  input wire logic config_bus_request_n,
  input wire logic config_strobe_n,
  input wire logic [7:0] program_bus
);

  typedef struct packed {
    mqf_cfg_s cfg;
    logic [3:0] cfg_idx;
    logic [1:0] req_pipe;
    logic strobe_prev;
    logic grant;
    logic alarm_n;
    logic in_cell;
    logic drop;
    logic [1:0] cur_q;
    logic [5:0] wpos;
    logic whalf;
    logic [8:0] hold;
    logic rd_active;
    logic [1:0] rq;
    logic [5:0] rpos;
    logic rhalf;
    logic [2:0] full_n;
    logic [2:0] thr;
    logic [2:0] ready;
    mqf_queue_s [2:0] q;
  } mqf_top_state_s;

  mqf_top_state_s st;
  mqf_top_state_s next_st;
  logic [17:0] mem [MQF_MEM_WORDS];
  logic mem_we;
  logic [11:0] mem_waddr;
  logic [17:0] mem_wdata;
  logic [12:0] base [3];
  logic [12:0] qlen [3];
  logic fifo_in_valid;
  logic fifo_in_ready;
  mqf_word_s fifo_in_word;
  mqf_word_s fifo_out_word;
  logic fifo_out_valid;

  ////////////////////////////////////////////////////////////////////////////////
  // Queue regions from the programmed lengths.
  logic [12:0] span [4];
  assign span[0] = '0;
  assign span[1] = 13'(st.cfg.queue1_length) << MQF_BLOCK_SHIFT;
  assign span[2] = (13'(st.cfg.queue1_length) + 13'(st.cfg.queue2_length)) << MQF_BLOCK_SHIFT;
  assign span[3] = 13'(MQF_MEM_WORDS);
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_region
      assign base[gi] = span[gi];
      assign qlen[gi] = span[gi+1] - span[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    logic [5:0] cs;
    logic [1:0] wq;
    logic [1:0] tq;
    logic take;
    logic at_start;
    logic wword;
    logic [17:0] word;
    logic [17:0] rword;
    logic radv;
    logic rend;
    logic [2:0] commit;
    logic [2:0] release_cell;
    logic [12:0] room;
    cs = st.cfg.cell_size_words;
    wq = write_enable[0] ? 2'd0 : (write_enable[1] ? 2'd1 : 2'd2);
    tq = 2'd0;
    take = 1'b0;
    at_start = 1'b0;
    wword = 1'b0;
    word = '0;
    rword = '0;
    radv = 1'b0;
    rend = 1'b0;
    commit = '0;
    release_cell = '0;
    room = '0;
    next_st = st;
    mem_we = 1'b0;
    mem_waddr = '0;
    mem_wdata = '0;
    fifo_in_valid = 1'b0;
    fifo_in_word = '0;

    next_st.req_pipe = {st.req_pipe[0], config_bus_request_n};
    next_st.grant = st.req_pipe[1];
    next_st.strobe_prev = config_strobe_n;
    if (!st.grant && st.strobe_prev && !config_strobe_n && st.cfg_idx < 4'(MQF_CFG_COUNT)) begin
      next_st.cfg_idx = st.cfg_idx + 1'b1;
      unique case (st.cfg_idx)
        4'h0: next_st.cfg.bus_format_cfg = program_bus[4:0];
        4'h1: next_st.cfg.queue1_length = program_bus[4:0];
        4'h2: next_st.cfg.queue2_length = program_bus[3:0];
        4'h3: next_st.cfg.cell_size_words = program_bus[5:0];
        4'h4: next_st.cfg.upper_threshold[0] = {program_bus, 1'b1};
        4'h5: next_st.cfg.lower_threshold[0] = {program_bus, 1'b0};
        4'h6: next_st.cfg.upper_threshold[1] = {program_bus, 1'b1};
        4'h7: next_st.cfg.lower_threshold[1] = {program_bus, 1'b0};
        4'h8: next_st.cfg.upper_threshold[2] = {program_bus, 1'b1};
        default: next_st.cfg.lower_threshold[2] = {program_bus, 1'b0};
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write side.
    // Data only while granted.
    take = st.grant && (write_enable != 3'b000) && st.alarm_n;
    at_start = !st.in_cell;
    tq = at_start ? wq : st.cur_q;
    if (framing_abort_in) begin
      next_st.alarm_n = 1'b1;
      next_st.in_cell = 1'b0;
      next_st.wpos = '0;
      next_st.whalf = 1'b0;
      next_st.q[st.cur_q].wr_off = st.q[st.cur_q].wr_start;
    end else if (take && (cell_start_in != at_start)) begin
      next_st.alarm_n = 1'b0;
      next_st.in_cell = 1'b0;
      next_st.wpos = '0;
      next_st.whalf = 1'b0;
      next_st.q[st.cur_q].wr_off = st.q[st.cur_q].wr_start;
    end else if (take) begin
      if (at_start) begin
        next_st.in_cell = 1'b1;
        next_st.cur_q = wq;
        next_st.drop = !st.q[wq].full_n;
      end
      if (!st.cfg.bus_format_cfg[MQF_FMT_INPUT_WIDTH]) begin
        wword = 1'b1;
        word = data_in;
      end else if (!st.whalf) begin
        next_st.hold = data_in[8:0];
        next_st.whalf = 1'b1;
        if (st.cfg.bus_format_cfg[MQF_FMT_INPUT_STUFF] && st.wpos == cs - 6'd1) begin
          wword = 1'b1;
          next_st.whalf = 1'b0;
          word = st.cfg.bus_format_cfg[MQF_FMT_INPUT_ORDER] ? {data_in[8:0], MQF_STUFF_BYTE}
                                                             : {MQF_STUFF_BYTE, data_in[8:0]};
        end
      end else begin
        wword = 1'b1;
        next_st.whalf = 1'b0;
        word = st.cfg.bus_format_cfg[MQF_FMT_INPUT_ORDER] ? {st.hold, data_in[8:0]} : {data_in[8:0], st.hold};
      end
      if (wword) begin
        if (!(at_start ? !st.q[wq].full_n : st.drop)) begin
          mem_we = 1'b1;
          mem_waddr = 12'(base[tq] + st.q[tq].wr_off);
          mem_wdata = word;
          next_st.q[tq].wr_off = (st.q[tq].wr_off == qlen[tq] - 13'd1) ? '0 : st.q[tq].wr_off + 13'd1;
        end
        next_st.wpos = st.wpos + 6'd1;
        if (st.wpos == cs - 6'd1) begin
          next_st.in_cell = 1'b0;
          next_st.wpos = '0;
          if (!(at_start ? !st.q[wq].full_n : st.drop)) begin
            commit[tq] = 1'b1;
            next_st.q[tq].wr_start = next_st.q[tq].wr_off;
          end
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read side.
    if (!st.rd_active && read_enable && read_queue_sel != 2'd3 && st.q[read_queue_sel].cells != '0) begin
      next_st.rd_active = 1'b1;
      next_st.rq = read_queue_sel;
      next_st.rpos = '0;
      next_st.rhalf = 1'b0;
    end
    rword = mem[12'(base[st.rq] + st.q[st.rq].rd_off)];
    if (st.rd_active && fifo_in_ready) begin
      fifo_in_valid = 1'b1;
      fifo_in_word.sof = (st.rpos == '0) && !st.rhalf;
      if (!st.cfg.bus_format_cfg[MQF_FMT_OUTPUT_WIDTH]) begin
        fifo_in_word.data = rword;
        radv = 1'b1;
      end else begin
        fifo_in_word.data = st.rhalf ? {rword[17:9], rword[17:9]} : {rword[8:0], rword[8:0]};
        next_st.rhalf = !st.rhalf;
        radv = st.rhalf;
        if (st.cfg.bus_format_cfg[MQF_FMT_OUTPUT_DESTUFF] && st.rpos == cs - 6'd1) begin
          radv = 1'b1;
        end
        if (radv) begin
          next_st.rhalf = 1'b0;
        end
      end
      if (radv) begin
        next_st.q[st.rq].rd_off = (st.q[st.rq].rd_off == qlen[st.rq] - 13'd1) ? '0 : st.q[st.rq].rd_off + 13'd1;
        next_st.rpos = st.rpos + 6'd1;
        if (st.rpos == cs - 6'd1) begin
          rend = 1'b1;
          next_st.rd_active = 1'b0;
          release_cell[st.rq] = 1'b1;
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cell counts and flags.
    for (int i = 0; i < 3; i++) begin
      next_st.q[i].cells = st.q[i].cells + 9'(commit[i]) - 9'(release_cell[i]);
      next_st.q[i].used_words = st.q[i].used_words + (commit[i] ? 13'(cs) : 13'd0)
                                - (release_cell[i] ? 13'(cs) : 13'd0);
      room = qlen[i] - next_st.q[i].used_words;
      next_st.full_n[i] = (room >= 13'(cs));
      next_st.q[i].full_n = next_st.full_n[i];
      next_st.ready[i] = (next_st.q[i].cells != '0);
      if (next_st.q[i].cells >= st.cfg.upper_threshold[i]) begin
        next_st.thr[i] = 1'b0;
      end else if (next_st.q[i].cells <= st.cfg.lower_threshold[i]) begin
        next_st.thr[i] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State and memory registers.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st <= '0;
      st.cfg.bus_format_cfg <= MQF_RST_BUS_FORMAT;
      st.cfg.queue1_length <= MQF_RST_Q1_LENGTH;
      st.cfg.queue2_length <= MQF_RST_Q2_LENGTH;
      st.cfg.cell_size_words <= MQF_RST_CELL_SIZE;
      st.cfg.upper_threshold <= {MQF_RST_Q3_UPPER, MQF_RST_Q2_UPPER, MQF_RST_Q1_UPPER};
      st.cfg.lower_threshold <= {MQF_RST_Q3_LOWER, MQF_RST_Q2_LOWER, MQF_RST_Q1_LOWER};
      st.req_pipe <= 2'b11;
      st.strobe_prev <= 1'b1;
      st.grant <= 1'b1;
      st.alarm_n <= 1'b1;
      st.full_n <= 3'b111;
      st.thr <= 3'b111;
      st.q[0].full_n <= 1'b1;
      st.q[1].full_n <= 1'b1;
      st.q[2].full_n <= 1'b1;
    end else begin
      st <= next_st;
    end
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output buffer and outputs.
  mqf_out_fifo #(
    .WIDTH(MQF_OUT_FIFO_WIDTH),
    .DEPTH(MQF_OUT_FIFO_DEPTH)
  ) u_out_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_word),
    .out_valid(fifo_out_valid),
    .out_ready(read_ready),
    .out_data(fifo_out_word)
  );

  assign data_path_grant = st.grant;
  assign framing_alarm_n = st.alarm_n;
  assign queue_full_n = st.full_n;
  assign queue_threshold_flag = st.thr;
  assign queue_cell_ready = st.ready;
  assign read_valid = fifo_out_valid;
  assign data_out = fifo_out_valid ? fifo_out_word.data : 18'h00000;
  assign cell_start_out = fifo_out_valid && fifo_out_word.sof;

endmodule : mqf_cell_fifo

// file: test/mqf_cell_fifo_properties.sv
// Concurrent checks on the ports of the three-queue cell FIFO.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module mqf_cell_fifo_checker
  import mqf_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Write side.
  input wire logic [2:0] write_enable,
  input wire logic framing_abort_in,
  input wire logic data_path_grant,
  input wire logic framing_alarm_n,
  input wire logic [2:0] queue_threshold_flag,
  input wire logic config_bus_request_n,
  // Read side.
  input wire logic [2:0] queue_cell_ready,
  input wire logic [17:0] data_out,
  input wire logic read_valid,
  input wire logic read_ready,
  input wire logic cell_start_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_grant_drop: assert property (
    !config_bus_request_n |-> ##3 !data_path_grant) else $error("Grant still high after request.");
  a_grant_open: assert property (
    config_bus_request_n |-> ##3 data_path_grant) else $error("Grant still low after release.");
  a_alarm_hold: assert property (
    !framing_alarm_n && !framing_abort_in |=> !framing_alarm_n) else $error("Alarm cleared without abort.");
  a_alarm_clear: assert property (
    framing_abort_in |=> framing_alarm_n) else $error("Abort left alarm set.");
  a_alarm_blocks: assert property (
    !framing_alarm_n |=> !$rose(queue_cell_ready[2])) else $error("Cell stored during alarm.");
  a_grant_blocks: assert property (
    !data_path_grant |=> !$rose(queue_cell_ready[0])) else $error("Cell stored while grant low.");
  a_ready_cause: assert property (
    $rose(queue_cell_ready[0]) |-> $past(write_enable[0])) else $error("Cell ready rose without write.");
  a_thr_cause: assert property (
    $fell(queue_threshold_flag[0]) |-> $past(write_enable[0])) else $error("Threshold fell without write.");
  a_idle_quiet: assert property (
    !read_valid |-> data_out == 18'h00000 && !cell_start_out) else $error("Output busy while not valid.");
  a_data_stand: assert property (
    read_valid && !read_ready |=> read_valid && $stable(data_out) && $stable(cell_start_out))
    else $error("Output word changed under stall.");
endmodule : mqf_cell_fifo_checker
bind mqf_cell_fifo mqf_cell_fifo_checker u_mqf_cell_fifo_checker (.sys_clk, .reset_n, .write_enable,
  .framing_abort_in, .data_path_grant, .framing_alarm_n, .queue_threshold_flag, .config_bus_request_n,
  .queue_cell_ready, .data_out, .read_valid, .read_ready, .cell_start_out);

// file: test/mqf_cell_source.sv
// Cell source model for the write side of the cell FIFO.
// Assumes the bench calls send from one process at a time.
`timescale 1ns/1ps
module mqf_cell_source
  import mqf_pkg::*;
#(
  parameter int WORDS = 10
) (
  // Clock and grant.
  input wire logic sys_clk,
  input wire logic data_path_grant,
  // Write side.
  output logic [17:0] data_in,
  output logic [2:0] write_enable,
  output logic cell_start_in
);
  initial begin
    data_in = 18'h3ffff;
    write_enable = 3'h0;
    cell_start_in = 1'b0;
  end
  ////////////////////////////////////////
  task automatic send(input int q, input logic [7:0] tag, input int bad, input bit slow);
    for (int i = 0; i < WORDS; i++) begin
      @(negedge sys_clk);
      while (data_path_grant !== 1'b1) begin
        write_enable = 3'h0;
        @(negedge sys_clk);
      end
      if (slow && i == 3) begin
        write_enable = 3'h0;
        data_in = ~data_in;
        @(negedge sys_clk);
      end
      cell_start_in = (i == 0) || (i == bad);
      write_enable = 3'(1 << q);
      data_in = {tag, 10'(i)};
    end
    @(negedge sys_clk);
    write_enable = 3'h0;
    cell_start_in = 1'b0;
    data_in = ~data_in;
  endtask : send
endmodule : mqf_cell_source

// file: test/test_multi_queue_cell_fifo.sv
// Self-checking bench for the three-queue cell FIFO.
// Assumes the cell source model drives the write side.
`timescale 1ns/1ps
module test_multi_queue_cell_fifo
  import mqf_pkg::*;
;
  logic sys_clk, reset_n, framing_abort_in, data_path_grant, framing_alarm_n, cell_start_in;
  logic read_enable, read_valid, read_ready, cell_start_out, config_bus_request_n, config_strobe_n;
  logic [17:0] data_in, data_out;
  logic [2:0] write_enable, queue_full_n, queue_threshold_flag, queue_cell_ready;
  logic [1:0] read_queue_sel;
  logic [7:0] program_bus;
  int failures, comparisons;
  logic [7:0] cfg [11] = '{8'h00, 8'h01, 8'h00, 8'h0a, 8'h02, 8'h01, 8'h01, 8'h00, 8'h02, 8'h01, 8'h1f};
  mqf_cell_fifo u_mqf_cell_fifo (.sys_clk, .reset_n, .data_in, .write_enable, .cell_start_in,
    .framing_abort_in, .data_path_grant, .framing_alarm_n, .queue_full_n, .queue_threshold_flag,
    .read_enable, .read_queue_sel, .queue_cell_ready, .data_out, .read_valid, .read_ready,
    .cell_start_out, .config_bus_request_n, .config_strobe_n, .program_bus);
  mqf_cell_source u_mqf_cell_source (.sys_clk, .data_path_grant, .data_in, .write_enable, .cell_start_in);
  ////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic cfg_write(input logic [7:0] value);
    @(negedge sys_clk);
    program_bus = value;
    config_strobe_n = 1'b0;
    @(negedge sys_clk);
    config_strobe_n = 1'b1;
  endtask : cfg_write
  task automatic read_cell(input logic [1:0] q, input logic [7:0] tag, input bit stall);
    int i;
    int n;
    i = 0;
    n = 0;
    @(negedge sys_clk);
    read_queue_sel = q;
    read_enable = 1'b1;
    @(negedge sys_clk);
    read_enable = 1'b0;
    while (i < 10 && n < 300) begin
      @(negedge sys_clk);
      n++;
      read_ready = !(stall && n % 3 == 0);
      if (read_valid === 1'b1 && read_ready) begin
        check("data_out", data_out, {tag, 10'(i)});
        check("cell_start_out", 18'(cell_start_out), 18'(i == 0));
        i++;
      end
    end
    check("words read", 18'(i), 18'h0000a);
  endtask : read_cell
  task automatic wrap_up;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    wrap_up;
  end
  initial begin
    failures = 0;
    comparisons = 0;
    reset_n = 1'b0;
    framing_abort_in = 1'b0;
    read_enable = 1'b0;
    read_queue_sel = 2'h0;
    read_ready = 1'b1;
    config_bus_request_n = 1'b1;
    config_strobe_n = 1'b1;
    program_bus = 8'h00;
    repeat (20) @(negedge sys_clk);
    reset_n = 1'b1;
    cfg_write(8'h1f);
    config_bus_request_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    check("data_path_grant", 18'(data_path_grant), 18'h0);
    foreach (cfg[k]) cfg_write(cfg[k]);
    config_bus_request_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    check("data_path_grant", 18'(data_path_grant), 18'h1);
    check("queue_full_n", 18'(queue_full_n), 18'h5);
    for (int c = 1; c <= 5; c++) begin
      u_mqf_cell_source.send(0, 8'(c), 0, c == 2);
      check("queue1 ready", 18'(queue_cell_ready[0]), 18'h1);
      check("queue1 threshold", 18'(queue_threshold_flag[0]), 18'(c < 5));
    end
    check("queue1 threshold", 18'(queue_threshold_flag[0]), 18'h0);
    u_mqf_cell_source.send(1, 8'h77, 0, 0);
    check("queue2 ready", 18'(queue_cell_ready[1]), 18'h0);
    for (int c = 1; c <= 5; c++) begin
      read_cell(2'h0, 8'(c), c == 1);
      check("queue1 threshold", 18'(queue_threshold_flag[0]), 18'(c >= 3));
      check("queue1 ready", 18'(queue_cell_ready[0]), 18'(c < 5));
    end
    u_mqf_cell_source.send(2, 8'h0b, 4, 0);
    check("framing_alarm_n", 18'(framing_alarm_n), 18'h0);
    check("queue3 ready", 18'(queue_cell_ready[2]), 18'h0);
    u_mqf_cell_source.send(2, 8'h0c, 0, 0);
    check("queue3 ready", 18'(queue_cell_ready[2]), 18'h0);
    @(negedge sys_clk);
    framing_abort_in = 1'b1;
    @(negedge sys_clk);
    framing_abort_in = 1'b0;
    check("framing_alarm_n", 18'(framing_alarm_n), 18'h1);
    u_mqf_cell_source.send(2, 8'h0d, 0, 0);
    check("queue3 ready", 18'(queue_cell_ready[2]), 18'h1);
    read_cell(2'h2, 8'h0d, 1'b1);
    check("queue3 ready", 18'(queue_cell_ready[2]), 18'h0);
    wrap_up;
  end
endmodule : test_multi_queue_cell_fifo
